//--- src/edge_tap_filter.sv
`timescale 1ns/100ps
module edge_tap_filter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] in_sample,
  input wire logic in_valid,
  input wire logic [2:0] tap_sel,
  output logic signed [rx_sigproc_pkg::SAMPLE_W:0] edge_value,
  output logic edge_valid
);
  localparam int unsigned W = rx_sigproc_pkg::SAMPLE_W;
  localparam int unsigned N = rx_sigproc_pkg::MAX_TAPS;
  logic signed [W-1:0] hist_q [N];

  function automatic logic [5:0] tap_count(input logic [2:0] sel);
    case (sel)
      3'h0: tap_count = 6'h04;
      3'h1: tap_count = 6'h06;
      3'h2: tap_count = 6'h08;
      3'h3: tap_count = 6'h08;
      3'h4: tap_count = 6'h10;
      3'h5: tap_count = 6'h12;
      3'h6: tap_count = 6'h18;
      default: tap_count = 6'h20;
    endcase
  endfunction

  wire [5:0] taps = tap_count(tap_sel);
  wire signed [W-1:0] oldest = hist_q[5'(taps - 6'h01)];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q[0] <= '0;
    end else if (in_valid) begin
      hist_q[0] <= in_sample;
    end
  end
  for (genvar k = 1; k < N; k++) begin : g_hist
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        hist_q[k] <= '0;
      end else if (in_valid) begin
        hist_q[k] <= hist_q[k-1];
      end
    end
  end

  // comb difference across the window: large where the level steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_value <= '0;
      edge_valid <= 1'b0;
    end else begin
      edge_valid <= in_valid;
      if (in_valid) begin
        edge_value <= (W+1)'(in_sample) - (W+1)'(oldest);
      end
    end
  end
endmodule

//--- src/rx_demod_signal_config.sv
// Our own choice: register access over APB.
`timescale 1ns/100ps
module rx_demod_signal_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_sigproc_pkg::ADDR_W-1:0] paddr,
  input wire logic [rx_sigproc_pkg::DATA_W-1:0] pwdata,
  output logic [rx_sigproc_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] cm_sample,
  input wire logic cm_sample_valid,
  input wire logic auto_detect_en,
  input wire logic mode_detected,
  input wire logic [1:0] detected_framing,
  input wire logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] i_sample,
  input wire logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] q_sample,
  input wire logic rm_sample_valid,
  input wire logic rx_frame_start,
  input wire logic rx_path_reset,
  output logic [1:0] cm_framing,
  output logic cm_edge,
  output logic cm_bit,
  output logic rm_bit,
  output logic rm_bit_valid,
  output logic subcarrier_detect,
  output logic phase_shift_detect,
  output logic collision,
  output logic bpsk_mode
);
  localparam int unsigned W = rx_sigproc_pkg::SAMPLE_W;
  localparam int unsigned CW = rx_sigproc_pkg::CORR_W;

  typedef enum logic [1:0] {SOF_IDLE, SOF_WAIT_EXTREME, SOF_DATA} sof_t;

  function automatic logic [W-1:0] magnitude(input logic signed [W:0] v);
    logic [W:0] a;
    a = v[W] ? (W+1)'(-v) : v;
    magnitude = (a[W]) ? {W{1'b1}} : a[W-1:0];
  endfunction

  logic [31:0] cm_q, cm_d, rm_q, rm_d;
  logic [31:0] rdata_q;

  // ---------------- APB slave, zero wait states ----------------
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire hit_cm = (paddr == rx_sigproc_pkg::CM_CONFIG_ADDR);
  wire hit_rm = (paddr == rx_sigproc_pkg::RM_CONFIG_ADDR);
  wire wr_cm = access_ph && pwrite && hit_cm;
  wire wr_rm = access_ph && pwrite && hit_rm;
  wire auto_write = auto_detect_en && mode_detected;
  wire [31:0] rd_mux = hit_cm ? cm_q : hit_rm ? rm_q : 32'h0000_0000;

  assign pready = 1'b1;
  assign pslverr = access_ph && !hit_cm && !hit_rm;
  assign prdata = rdata_q;

  // the detector update is applied after the software write so it wins
  always_comb begin
    cm_d = wr_cm ? (pwdata & rx_sigproc_pkg::CM_WMASK) : cm_q;
    if (auto_write) begin
      cm_d[rx_sigproc_pkg::FRAMING_MSB:rx_sigproc_pkg::FRAMING_LSB] =
        detected_framing;
    end
    rm_d = wr_rm ? (pwdata & rx_sigproc_pkg::RM_WMASK) : rm_q;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_q <= rx_sigproc_pkg::CM_RESET;
      rm_q <= rx_sigproc_pkg::RM_RESET;
      rdata_q <= 32'h0000_0000;
    end else begin
      cm_q <= cm_d;
      rm_q <= rm_d;
      if (setup_ph && !pwrite) begin
        rdata_q <= rd_mux;
      end
    end
  end

  // ---------------- configuration fields ----------------
  wire [2:0] tap_sel = cm_q[rx_sigproc_pkg::TAP_MSB:rx_sigproc_pkg::TAP_LSB];
  wire [12:0] edge_th =
    cm_q[rx_sigproc_pkg::EDGE_TH_MSB:rx_sigproc_pkg::EDGE_TH_LSB];
  wire [12:0] bit_th =
    cm_q[rx_sigproc_pkg::BIT_TH_MSB:rx_sigproc_pkg::BIT_TH_LSB];
  wire [2:0] iq_mode = rm_q[rx_sigproc_pkg::IQ_MSB:rx_sigproc_pkg::IQ_LSB];
  wire resync_eq = rm_q[rx_sigproc_pkg::RESYNC_BIT];
  wire corr_clear = rm_q[rx_sigproc_pkg::CORR_CLR_BIT];
  wire filt_off = rm_q[rx_sigproc_pkg::FILT_OFF_BIT];
  wire early_data = rm_q[rx_sigproc_pkg::EARLY_DATA_BIT];
  wire [3:0] min_level = rm_q[rx_sigproc_pkg::MIN_MSB:rx_sigproc_pkg::MIN_LSB];
  wire [3:0] min_level_p =
    rm_q[rx_sigproc_pkg::MINP_MSB:rx_sigproc_pkg::MINP_LSB];
  wire short_eval = rm_q[rx_sigproc_pkg::SHORT_EVAL_BIT];
  wire [1:0] coll_sel = rm_q[rx_sigproc_pkg::COLL_MSB:rx_sigproc_pkg::COLL_LSB];
  wire sync_high = rm_q[rx_sigproc_pkg::SYNC_HIGH_BIT];

  assign cm_framing =
    cm_q[rx_sigproc_pkg::FRAMING_MSB:rx_sigproc_pkg::FRAMING_LSB];
  assign bpsk_mode = rm_q[rx_sigproc_pkg::BPSK_BIT];

  // ---------------- card-mode sample processor ----------------
  logic signed [W:0] edge_value;
  logic edge_valid;
  edge_tap_filter u_edge (
    .pclk(pclk),
    .presetn(presetn),
    .in_sample(cm_sample),
    .in_valid(cm_sample_valid),
    .tap_sel(tap_sel),
    .edge_value(edge_value),
    .edge_valid(edge_valid)
  );
  wire [W-1:0] edge_mag = magnitude(edge_value);
  wire edge_hit = {1'b0, edge_mag} > edge_th;
  wire bit_hit = $signed(cm_sample) > $signed({1'b0, bit_th});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cm_edge <= 1'b0;
      cm_bit <= 1'b0;
    end else begin
      if (edge_valid) begin
        cm_edge <= edge_hit;
      end
      if (cm_sample_valid) begin
        cm_bit <= bit_hit;
      end
    end
  end

  // ---------------- reader-mode front: pre-filter ----------------
  logic signed [W-1:0] i_filt, q_filt;
  logic i_fvalid;
  sample_prefilter u_pre_i (
    .pclk(pclk),
    .presetn(presetn),
    .in_sample(i_sample),
    .in_valid(rm_sample_valid),
    .avg_en(rm_q[rx_sigproc_pkg::AVG_BIT]),
    .rect_en(rm_q[rx_sigproc_pkg::RECT_BIT]),
    .out_sample(i_filt),
    .out_valid(i_fvalid)
  );
  sample_prefilter u_pre_q (
    .pclk(pclk),
    .presetn(presetn),
    .in_sample(q_sample),
    .in_valid(rm_sample_valid),
    .avg_en(rm_q[rx_sigproc_pkg::AVG_BIT]),
    .rect_en(rm_q[rx_sigproc_pkg::RECT_BIT]),
    .out_sample(q_filt),
    .out_valid()
  );

  // ---------------- channel selection ----------------
  logic first_seen_q, first_is_q_q;
  wire [W-1:0] mag_i = magnitude((W+1)'(i_filt));
  wire [W-1:0] mag_q = magnitude((W+1)'(q_filt));
  wire i_strong = mag_i >= mag_q;
  wire i_above = mag_i[W-1:W-4] > min_level;
  wire q_above = mag_q[W-1:W-4] > min_level;
  wire signed [W:0] sum_iq = (W+1)'(i_filt) + (W+1)'(q_filt);
  wire signed [W:0] ext_i = (W+1)'(i_filt);
  wire signed [W:0] ext_q = (W+1)'(q_filt);
  wire signed [W:0] sel_sig =
    (iq_mode == rx_sigproc_pkg::IQ_BOTH) ? sum_iq :
    (iq_mode == rx_sigproc_pkg::IQ_ONLY_I) ? ext_i :
    (iq_mode == rx_sigproc_pkg::IQ_ONLY_Q) ? ext_q :
    (iq_mode == rx_sigproc_pkg::IQ_STRONGEST) ? (i_strong ? ext_i : ext_q) :
    (iq_mode == rx_sigproc_pkg::IQ_FIRST) ? (first_is_q_q ? ext_q : ext_i) :
    '0;
  wire [W-1:0] sel_mag = magnitude(sel_sig);
  wire sub_hit = sel_mag[W-1:W-4] > min_level;

  // collision: the weaker channel against a fraction of the stronger one
  wire [W-1:0] primary = i_strong ? mag_i : mag_q;
  wire [W-1:0] secondary = i_strong ? mag_q : mag_i;
  wire [W-1:0] coll_th =
    (coll_sel == rx_sigproc_pkg::COLL_EIGHTH) ? (primary >> 3) :
    (coll_sel == rx_sigproc_pkg::COLL_QUARTER) ? (primary >> 2) :
    (primary >> 1);
  wire coll_hit = (coll_sel != 2'h3) && sub_hit && (secondary > coll_th);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_seen_q <= 1'b0;
      first_is_q_q <= 1'b0;
      subcarrier_detect <= 1'b0;
      collision <= 1'b0;
    end else begin
      if (rx_frame_start) begin
        first_seen_q <= 1'b0;
        first_is_q_q <= 1'b0;
      end else if (i_fvalid && !first_seen_q && (i_above || q_above)) begin
        first_seen_q <= 1'b1;
        first_is_q_q <= !i_above;
      end
      if (i_fvalid) begin
        subcarrier_detect <= sub_hit;
        collision <= coll_hit;
      end
    end
  end

  // ---------------- correlator and bit grid ----------------
  sof_t sof_q;
  logic [4:0] eval_cnt_q;
  logic signed [CW-1:0] corr_acc_q, corr_last_q;
  logic [5:0] hist_q;
  wire [4:0] eval_len = short_eval ? rx_sigproc_pkg::EVAL_SHORT :
    rx_sigproc_pkg::EVAL_LONG;
  wire win_end = i_fvalid && (eval_cnt_q == eval_len - 5'h01);
  wire signed [CW-1:0] step = sel_sig[W] ? -6'sd1 : 6'sd1;
  wire signed [CW-1:0] corr_new = corr_acc_q + step;
  wire corr_equal = corr_new == corr_last_q;
  wire resync = win_end && (sof_q == SOF_WAIT_EXTREME) && resync_eq &&
    corr_equal;
  // the first extreme is seen once the correlation turns back
  wire turned = sync_high ? (corr_new < corr_last_q) :
    (corr_new > corr_last_q);
  wire accept = (sof_q == SOF_DATA) ||
    ((sof_q == SOF_WAIT_EXTREME) && early_data);

  // bpsk phase patterns over the sliced correlation history
  wire [5:0] hist_d = {hist_q[4:0], !corr_new[CW-1]};
  wire m0110 = hist_d[4:1] == 4'h6;
  wire m1110 = hist_d[5:2] == 4'he;
  wire m0111 = hist_d[3:0] == 4'h7;
  wire bpsk_bit = filt_off ? m0110 : (m0110 && !m1110 && !m0111);
  wire signed [CW:0] corr_diff = (CW+1)'(corr_new) - (CW+1)'(corr_last_q);
  wire [CW:0] diff_mag = corr_diff[CW] ? (CW+1)'(-corr_diff) : corr_diff;
  wire phase_hit = bpsk_mode && (diff_mag > (CW+1)'(min_level_p));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eval_cnt_q <= '0;
      corr_acc_q <= '0;
      corr_last_q <= '0;
      hist_q <= '0;
    end else if (rx_path_reset) begin
      eval_cnt_q <= '0;
      if (corr_clear) begin
        corr_acc_q <= '0;
        corr_last_q <= '0;
        hist_q <= '0;
      end
    end else if (i_fvalid) begin
      if (resync) begin
        // shift the grid by half a window to centre on the transition
        eval_cnt_q <= eval_len >> 1;
      end else if (win_end) begin
        eval_cnt_q <= '0;
      end else begin
        eval_cnt_q <= eval_cnt_q + 5'h01;
      end
      if (win_end) begin
        corr_acc_q <= '0;
        corr_last_q <= corr_new;
        hist_q <= hist_d;
      end else begin
        corr_acc_q <= corr_new;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sof_q <= SOF_IDLE;
    end else begin
      case (sof_q)
        SOF_IDLE: begin
          if (rx_frame_start) begin
            sof_q <= SOF_WAIT_EXTREME;
          end
        end
        SOF_WAIT_EXTREME: begin
          if (rx_path_reset) begin
            sof_q <= SOF_IDLE;
          end else if (win_end && turned) begin
            sof_q <= SOF_DATA;
          end
        end
        default: begin
          if (rx_path_reset) begin
            sof_q <= SOF_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rm_bit <= 1'b0;
      rm_bit_valid <= 1'b0;
      phase_shift_detect <= 1'b0;
    end else begin
      rm_bit_valid <= win_end && accept && !rx_path_reset;
      if (win_end) begin
        rm_bit <= bpsk_mode ? bpsk_bit : !corr_new[CW-1];
        phase_shift_detect <= phase_hit;
      end
    end
  end

  // ---------------- checks ----------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence detect_pulse;
    auto_detect_en && mode_detected;
  endsequence

  auto_framing_a: assert property (detect_pulse |=>
    cm_framing == $past(detected_framing))
    else $error("framing not taken from mode detector");
  rsvd_read_a: assert property (setup_ph && !pwrite && hit_rm |=>
    prdata[31:24] == 8'h00 && prdata[1] == 1'b0)
    else $error("reserved reader bits read nonzero");
  edge_dec_a: assert property (edge_valid |=>
    cm_edge == ({1'b0, $past(edge_mag)} > $past(edge_th)))
    else $error("edge decision mismatch");
  iq_only_i_a: assert property (i_fvalid && iq_mode == 3'h1 |=>
    subcarrier_detect == ($past(mag_i[W-1:W-4]) > $past(min_level)))
    else $error("I-only mode used another channel");
  corr_clr_a: assert property (rx_path_reset && corr_clear |=>
    corr_acc_q == '0 && corr_last_q == '0)
    else $error("correlator not cleared on path reset");
  coll_off_a: assert property (coll_sel == 2'h3 && i_fvalid |=>
    !collision)
    else $error("collision flagged while disabled");
  sequence late_window;
    win_end && !accept && !rx_path_reset;
  endsequence
  sof_gate_a: assert property (late_window |=> !rm_bit_valid)
    else $error("data delivered before first extreme");
  sequence pattern_window;
    win_end && bpsk_mode && filt_off && accept && !rx_path_reset;
  endsequence
  bpsk_raw_a: assert property (pattern_window |=>
    rm_bit == $past(m0110) && rm_bit_valid)
    else $error("unfiltered bpsk bit mismatch");
  resync_grid_a: assert property (resync && !rx_path_reset |=>
    eval_cnt_q == ($past(eval_len) >> 1))
    else $error("grid not realigned on equal correlation");
endmodule

//--- src/rx_sigproc_pkg.sv
package rx_sigproc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned SAMPLE_W = 12;
  localparam int unsigned THRESH_W = 13;
  localparam int unsigned CORR_W = 6;

  // register indices; the bus address is four times the index
  localparam logic [ADDR_W-1:0] CM_CONFIG_INDEX = 12'h01b;
  localparam logic [ADDR_W-1:0] RM_CONFIG_INDEX = 12'h01c;
  localparam logic [ADDR_W-1:0] CM_CONFIG_ADDR = 12'h06c;
  localparam logic [ADDR_W-1:0] RM_CONFIG_ADDR = 12'h070;

  localparam logic [DATA_W-1:0] CM_RESET = 32'h0000_0000;
  localparam logic [DATA_W-1:0] RM_RESET = 32'h0008_0000;
  localparam logic [DATA_W-1:0] CM_WMASK = 32'h7fff_ffff;
  localparam logic [DATA_W-1:0] RM_WMASK = 32'h00ff_fffd;

  // card-mode config fields
  localparam int unsigned FRAMING_MSB = 30;
  localparam int unsigned FRAMING_LSB = 29;
  localparam int unsigned TAP_MSB = 28;
  localparam int unsigned TAP_LSB = 26;
  localparam int unsigned EDGE_TH_MSB = 25;
  localparam int unsigned EDGE_TH_LSB = 13;
  localparam int unsigned BIT_TH_MSB = 12;
  localparam int unsigned BIT_TH_LSB = 0;

  // reader-mode config fields
  localparam int unsigned IQ_MSB = 23;
  localparam int unsigned IQ_LSB = 21;
  localparam int unsigned RESYNC_BIT = 19;
  localparam int unsigned CORR_CLR_BIT = 18;
  localparam int unsigned FILT_OFF_BIT = 17;
  localparam int unsigned EARLY_DATA_BIT = 16;
  localparam int unsigned MIN_MSB = 15;
  localparam int unsigned MIN_LSB = 12;
  localparam int unsigned MINP_MSB = 11;
  localparam int unsigned MINP_LSB = 8;
  localparam int unsigned SHORT_EVAL_BIT = 7;
  localparam int unsigned COLL_MSB = 6;
  localparam int unsigned COLL_LSB = 5;
  localparam int unsigned AVG_BIT = 4;
  localparam int unsigned RECT_BIT = 3;
  localparam int unsigned SYNC_HIGH_BIT = 2;
  localparam int unsigned BPSK_BIT = 0;

  typedef enum logic [1:0] {
    FRAMING_TYPE_A, FRAMING_SYNC_F0, FRAMING_PROPRIETARY, FRAMING_TYPE_B
  } framing_t;

  localparam logic [2:0] IQ_BOTH = 3'h0;
  localparam logic [2:0] IQ_ONLY_I = 3'h1;
  localparam logic [2:0] IQ_ONLY_Q = 3'h2;
  localparam logic [2:0] IQ_STRONGEST = 3'h4;
  localparam logic [2:0] IQ_FIRST = 3'h5;

  localparam logic [1:0] COLL_EIGHTH = 2'h0;
  localparam logic [1:0] COLL_QUARTER = 2'h1;
  localparam logic [1:0] COLL_HALF = 2'h2;

  localparam logic [4:0] EVAL_SHORT = 5'h08;
  localparam logic [4:0] EVAL_LONG = 5'h10;
  localparam logic [1:0] AVG_GROUP_LAST = 2'h3;
  localparam int unsigned MAX_TAPS = 32;

endpackage

//--- src/sample_prefilter.sv
`timescale 1ns/100ps
module sample_prefilter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] in_sample,
  input wire logic in_valid,
  input wire logic avg_en,
  input wire logic rect_en,
  output logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] out_sample,
  output logic out_valid
);
  localparam int unsigned W = rx_sigproc_pkg::SAMPLE_W;
  logic signed [W+1:0] acc_q, acc_d;
  logic [1:0] cnt_q;
  logic signed [W:0] doubled;
  logic signed [W-1:0] shaped;
  // doubling with saturation pushes the sine toward a square wave
  assign doubled = {in_sample, 1'b0};
  assign shaped = !rect_en ? in_sample :
    (doubled[W] != doubled[W-1]) ? {doubled[W], {(W-1){~doubled[W]}}} :
    doubled[W-1:0];
  assign acc_d = (cnt_q == 2'h0) ? (W+2)'(shaped) : acc_q + (W+2)'(shaped);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      cnt_q <= '0;
      out_sample <= '0;
      out_valid <= 1'b0;
    end else begin
      out_valid <= 1'b0;
      if (in_valid && !avg_en) begin
        out_sample <= shaped;
        out_valid <= 1'b1;
        cnt_q <= '0;
      end else if (in_valid) begin
        acc_q <= acc_d;
        cnt_q <= cnt_q + 2'h1;
        if (cnt_q == rx_sigproc_pkg::AVG_GROUP_LAST) begin
          out_sample <= acc_d[W+1:2];
          out_valid <= 1'b1;
        end
      end
    end
  end
endmodule

//--- testbench/adc_model.sv
`timescale 1ns/100ps
module adc_model (
  input wire logic pclk,
  output logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] cm_sample,
  output logic cm_sample_valid,
  output logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] i_sample,
  output logic signed [rx_sigproc_pkg::SAMPLE_W-1:0] q_sample,
  output logic rm_sample_valid
);
  initial begin
    cm_sample = 12'h000;
    i_sample = 12'h000;
    q_sample = 12'h000;
    cm_sample_valid = 1'b0;
    rm_sample_valid = 1'b0;
  end
  // one-cycle strobe; the lines then flip so a stale sample never matches
  task automatic send(input logic [11:0] cm, input logic [11:0] iq);
    @(posedge pclk);
    cm_sample <= cm;
    i_sample <= iq;
    q_sample <= ~iq;
    cm_sample_valid <= 1'b1;
    rm_sample_valid <= 1'b1;
    @(posedge pclk);
    cm_sample <= ~cm;
    i_sample <= ~iq;
    q_sample <= iq;
    cm_sample_valid <= 1'b0;
    rm_sample_valid <= 1'b0;
  endtask
endmodule

//--- testbench/tb.sv
`timescale 1ns/100ps
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] cm_s, i_s, q_s;
  logic cm_v, rm_v, auto_en, mdet, fstart, preset_rx, err;
  logic [1:0] dframe, cm_framing;
  logic cm_edge, cm_bit, rm_bit, rm_bit_valid, sc_det, ps_det, coll, bpsk;
  int num_errors = 0;
  int comparisons = 0;
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  adc_model adc (.pclk(pclk), .cm_sample(cm_s), .cm_sample_valid(cm_v),
    .i_sample(i_s), .q_sample(q_s), .rm_sample_valid(rm_v));
  rx_demod_signal_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cm_sample(cm_s),
    .cm_sample_valid(cm_v), .auto_detect_en(auto_en), .mode_detected(mdet),
    .detected_framing(dframe), .i_sample(i_s), .q_sample(q_s),
    .rm_sample_valid(rm_v), .rx_frame_start(fstart),
    .rx_path_reset(preset_rx), .cm_framing(cm_framing), .cm_edge(cm_edge),
    .cm_bit(cm_bit), .rm_bit(rm_bit), .rm_bit_valid(rm_bit_valid),
    .subcarrier_detect(sc_det), .phase_shift_detect(ps_det),
    .collision(coll), .bpsk_mode(bpsk));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic test_regs();
    apb(1'b0, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, rx_sigproc_pkg::RM_CONFIG_ADDR, 32'h0);
    chk(rd, 32'h0008_0000);
    apb(1'b1, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'hffff_ffff);
    apb(1'b0, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'h0);
    chk(rd, 32'h7fff_ffff);
    chk({30'h0, cm_framing}, 32'h3);
    apb(1'b1, rx_sigproc_pkg::RM_CONFIG_ADDR, 32'hffff_ffff);
    apb(1'b0, rx_sigproc_pkg::RM_CONFIG_ADDR, 32'h0);
    chk(rd, 32'h00ff_fffd);
    chk({31'h0, bpsk}, 32'h1);
    apb(1'b1, 12'h074, 32'h1234_5678);
    chk({31'h0, err}, 32'h1);
    $display("test regs done");
  endtask
  task automatic test_auto();
    auto_en <= 1'b1;
    for (int f = 0; f < 4; f++) begin
      @(posedge pclk);
      mdet <= 1'b1;
      dframe <= f[1:0];
      @(posedge pclk);
      mdet <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({30'h0, cm_framing}, f);
      apb(1'b0, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'h0);
      chk({30'h0, rd[30:29]}, f);
    end
    auto_en <= 1'b0;
    @(posedge pclk);
    mdet <= 1'b1;
    dframe <= 2'h1;
    @(posedge pclk);
    mdet <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({30'h0, cm_framing}, 32'h3);
    $display("test auto done");
  endtask
  task automatic test_bit();
    apb(1'b1, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'h0000_0064);
    adc.send(12'h065, 12'h100);
    repeat (3) @(posedge pclk);
    chk({31'h0, cm_bit}, 32'h1);
    adc.send(12'h064, 12'h100);
    repeat (3) @(posedge pclk);
    chk({31'h0, cm_bit}, 32'h0);
    adc.send(12'hf38, 12'h100);
    repeat (3) @(posedge pclk);
    chk({31'h0, cm_bit}, 32'h0);
    $display("test bit done");
  endtask
  task automatic test_edge();
    // four taps, edge threshold 0x100: a step stands for four samples
    apb(1'b1, rx_sigproc_pkg::CM_CONFIG_ADDR, 32'h0020_0000);
    for (int n = 0; n < 9; n++) begin
      adc.send((n < 4) ? 12'h000 : 12'h400, 12'h100);
      repeat (3) @(posedge pclk);
      chk({31'h0, cm_edge}, 32'(n >= 4 && n < 8));
      chk({31'h0, cm_bit}, 32'(n >= 4));
    end
    $display("test edge done");
  endtask
  task automatic test_reader();
    // I only, min level 2, eight-sample window, collision off;
    // the second pass adds early data, BPSK, raw 0110 and phase level 4
    logic valid_exp;
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, rx_sigproc_pkg::RM_CONFIG_ADDR,
          (p == 0) ? 32'h0024_20e0 : 32'h0027_24e1);
      @(posedge pclk);
      preset_rx <= 1'b1;
      @(posedge pclk);
      preset_rx <= 1'b0;
      fstart <= 1'b1;
      @(posedge pclk);
      fstart <= 1'b0;
      for (int n = 0; n < 16; n++) begin
        adc.send(12'h000, 12'h400);
        @(posedge pclk);
        @(negedge pclk);
        valid_exp = (n == 15) || (p == 1 && n == 7);
        chk({31'h0, rm_bit_valid}, {31'h0, valid_exp});
        chk({31'h0, sc_det}, 32'h1);
        chk({31'h0, coll}, 32'h0);
        chk({31'h0, ps_det}, 32'(p == 1 && n >= 7 && n < 15));
        if (n == 7 || n == 15) begin
          chk({31'h0, rm_bit}, 32'(p == 0));
        end
      end
    end
    $display("test reader done");
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    // the whole run is well under this many cycles
    repeat (5000) @(posedge pclk);
    num_errors++;
    final_report();
  end
  initial begin
    presetn = 1'b0;
    {psel, penable, pwrite, auto_en, mdet, fstart, preset_rx} = 7'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    dframe = 2'h0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    test_regs();
    test_auto();
    test_bit();
    test_edge();
    test_reader();
    final_report();
  end
endmodule
